// >>> verilog/pmf_pkg.sv
// constants for the power monitor flag, enable and pin-lock block
// Overview of operation
// - deep-sleep wake sets bit 15; reset-vector read clears
// - main supply failure clears bit 15 always
// - supervisor flags 13,12 clear by write/reset-vector read
// - soft power-on reset sets bit 10
// - reset pin source sets bit 9
// - soft brownout sets bit 8
// - bit 6 clears by write or enable-selected vector
// - bit 2 clears by write or enable-selected vector
// - monitor flags 5,1 clear only by write
// - delay expiry sets bits 4,0; interrupt-vector read clears
// - reserved bits read zero, ignore writes
// - enable 13: main overlevel causes power-on reset
// - enable 12 (reset 1): main underlevel causes reset
// - enable 9: core overlevel causes power-on reset
// - enable 8 (reset 1): core underlevel causes reset
// - monitor irq enables 5,1 clear on interrupt-vector read
// - pin lock resets 0, clears by write/power cycle
// - pin lock holds pins through deepest sleep
// - flags 13,12,6,2 take power-up sequence value
// - soft reset triggers self-clear after firing
// - side event mask blocks that side's events
package pmf_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] PMF_ADDR_FLAGS   = 8'h00;
   localparam logic [7:0] PMF_ADDR_ENABLES = 8'h04;
   localparam logic [7:0] PMF_ADDR_LOCK    = 8'h08;
   localparam logic [7:0] PMF_ADDR_CTRL    = 8'h0C;
   localparam logic [7:0] PMF_ADDR_RSTVEC  = 8'h10;
   localparam logic [7:0] PMF_ADDR_IRQVEC  = 8'h14;
   // ----------------------------------------------------------------
   // flag bit positions
   // ----------------------------------------------------------------
   localparam int PMF_F_WAKE      = 15;
   localparam int PMF_F_CORE_SV   = 13;
   localparam int PMF_F_MAIN_SV   = 12;
   localparam int PMF_F_SOFT_POR  = 10;
   localparam int PMF_F_RST_PIN   = 9;
   localparam int PMF_F_SOFT_BOR  = 8;
   localparam int PMF_F_MAIN_LVL  = 6;
   localparam int PMF_F_MAIN_MON  = 5;
   localparam int PMF_F_MAIN_DLY  = 4;
   localparam int PMF_F_CORE_LVL  = 2;
   localparam int PMF_F_CORE_MON  = 1;
   localparam int PMF_F_CORE_DLY  = 0;
   // enable bit positions
   localparam int PMF_E_MAIN_OVR  = 13;
   localparam int PMF_E_MAIN_UND  = 12;
   localparam int PMF_E_CORE_OVR  = 9;
   localparam int PMF_E_CORE_UND  = 8;
   // control register bits
   localparam int PMF_C_SOFT_POR  = 3;
   localparam int PMF_C_SOFT_BOR  = 2;
   localparam int PMF_C_MAIN_MASK = 1;
   localparam int PMF_C_CORE_MASK = 0;
   // ----------------------------------------------------------------
   // writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] PMF_FLAGS_MASK = 16'hB777;
   localparam logic [15:0] PMF_EN_MASK    = 16'h3377;
   localparam logic [15:0] PMF_EN_RESET   = 16'h1100;
   localparam logic [15:0] PMF_LOCK_MASK  = 16'h0001;
   localparam logic [15:0] PMF_CTRL_MASK  = 16'h0003;
   // flags that take the power-up sequence value
   localparam logic [15:0] PMF_SEQ_MASK   = 16'h3044;
   localparam logic [1:0]  PMF_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  PMF_RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/pmf_top.sv
// power monitor flags, reset enables and pin lock with axi4-lite slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module pmf_top
   import pmf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [15:0] seq_flag_value,
   input  wire logic        wake_from_deep_sleep,
   input  wire logic        main_power_fail,
   input  wire logic        reset_pin_source,
   input  wire logic        core_sv_event,
   input  wire logic        main_sv_event,
   input  wire logic        core_lvl_event,
   input  wire logic        main_lvl_event,
   input  wire logic        core_mon_event,
   input  wire logic        main_mon_event,
   input  wire logic        core_dly_event,
   input  wire logic        main_dly_event,
   input  wire logic        deep_sleep_active,
   output logic             por_request,
   output logic             bor_request,
   output logic             pin_hold,
   output logic             pm_irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] en;
      logic        lock;
      logic [1:0]  evmask;
      logic        por;
      logic        swp;
      logic        bor;
      logic        seq_load;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [15:0] w_data;
      logic [1:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  ev_s1;
      logic [2:0]  ev_s2;
      logic [2:0]  ev_s3;
   } pmf_state_t;

   pmf_state_t st_ff;
   pmf_state_t nxt_st;

   logic        wr_fire;
   logic        rd_fire;
   logic [15:0] set_v;
   logic [15:0] wr_clr;
   logic [15:0] vec_clr;
   logic [15:0] wbits;
   logic [31:0] rd_val;
   logic        rd_ok;
   logic        rst_vec_rd;
   logic        irq_vec_rd;
   logic        main_ok;
   logic        core_ok;
   logic [2:0]  ev_in;

   assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
   assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
   assign s_axi_arready = ~st_ff.rvalid;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;
   assign por_request   = st_ff.por;
   assign bor_request   = st_ff.bor;
   assign pin_hold      = st_ff.lock & deep_sleep_active;
   // ----------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------
   assign pm_irq = |(st_ff.flags & st_ff.en & 16'h0077);

   // asynchronous pins pass three stages; a pin counts when stages 2 and 3 both read high
   assign ev_in = {wake_from_deep_sleep, main_power_fail, reset_pin_source};

   always_comb begin
      wr_fire    = (st_ff.aw_got | s_axi_awvalid) & (st_ff.w_got | s_axi_wvalid)
                   & ~st_ff.bvalid;
      rd_fire    = s_axi_arvalid & ~st_ff.rvalid;
      rst_vec_rd = rd_fire & (s_axi_araddr == PMF_ADDR_RSTVEC);
      irq_vec_rd = rd_fire & (s_axi_araddr == PMF_ADDR_IRQVEC);
      main_ok    = ~st_ff.evmask[PMF_C_MAIN_MASK];
      core_ok    = ~st_ff.evmask[PMF_C_CORE_MASK];
      // hardware set terms
      set_v = 16'h0000;
      set_v[PMF_F_WAKE]     = st_ff.ev_s2[2] & st_ff.ev_s3[2];
      set_v[PMF_F_RST_PIN]  = st_ff.ev_s2[0] & st_ff.ev_s3[0];
      // only a software trigger marks bit 10; supervisor resets do not
      set_v[PMF_F_SOFT_POR] = st_ff.swp;
      set_v[PMF_F_SOFT_BOR] = st_ff.bor;
      set_v[PMF_F_CORE_SV]  = core_ok & core_sv_event;
      set_v[PMF_F_MAIN_SV]  = main_ok & main_sv_event;
      set_v[PMF_F_CORE_LVL] = core_ok & core_lvl_event;
      set_v[PMF_F_MAIN_LVL] = main_ok & main_lvl_event;
      set_v[PMF_F_CORE_MON] = core_ok & core_mon_event;
      set_v[PMF_F_MAIN_MON] = main_ok & main_mon_event;
      set_v[PMF_F_CORE_DLY] = core_ok & core_dly_event;
      set_v[PMF_F_MAIN_DLY] = main_ok & main_dly_event;
      // vector-read clear terms
      vec_clr = 16'h0000;
      vec_clr[PMF_F_WAKE]     = rst_vec_rd;
      vec_clr[PMF_F_CORE_SV]  = rst_vec_rd;
      vec_clr[PMF_F_MAIN_SV]  = rst_vec_rd;
      vec_clr[PMF_F_SOFT_POR] = rst_vec_rd;
      vec_clr[PMF_F_RST_PIN]  = rst_vec_rd;
      vec_clr[PMF_F_SOFT_BOR] = rst_vec_rd;
      vec_clr[PMF_F_MAIN_LVL] = st_ff.en[PMF_E_MAIN_UND] ? rst_vec_rd : irq_vec_rd;
      vec_clr[PMF_F_CORE_LVL] = st_ff.en[PMF_E_CORE_UND] ? rst_vec_rd : irq_vec_rd;
      vec_clr[PMF_F_MAIN_DLY] = irq_vec_rd;
      vec_clr[PMF_F_CORE_DLY] = irq_vec_rd;
      // monitor flags 5 and 1 have no vector clear
      // write data with byte lanes
      wbits = st_ff.w_got ? st_ff.w_data : s_axi_wdata[15:0];
      wr_clr = 16'h0000;

      nxt_st = st_ff;
      nxt_st.ev_s1 = ev_in;
      nxt_st.ev_s2 = st_ff.ev_s1;
      nxt_st.ev_s3 = st_ff.ev_s2;
      nxt_st.por = 1'b0;
      nxt_st.swp = 1'b0;
      nxt_st.bor = 1'b0;
      nxt_st.seq_load = 1'b0;

      // ------------------------------------------------------------
      // write channel
      // ------------------------------------------------------------
      if (s_axi_awvalid & s_axi_awready) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.w_data = s_axi_wdata[15:0];
         nxt_st.w_strb = s_axi_wstrb[1:0];
      end
      if (s_axi_bvalid & s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      nxt_st.en = st_ff.en;
      if (irq_vec_rd) begin
         nxt_st.en[5] = 1'b0;
         nxt_st.en[1] = 1'b0;
      end

      if (wr_fire) begin
         logic [7:0]  wa;
         logic [1:0]  ws;
         logic [15:0] lane;
         wa   = st_ff.aw_got ? st_ff.aw_addr : s_axi_awaddr;
         ws   = st_ff.w_got ? st_ff.w_strb : s_axi_wstrb[1:0];
         lane = {{8{ws[1]}}, {8{ws[0]}}};
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = PMF_RESP_OKAY;
         case (wa)
            PMF_ADDR_FLAGS: begin
               // software clears a flag by writing it to 0
               wr_clr = lane & ~wbits & PMF_FLAGS_MASK;
            end
            PMF_ADDR_ENABLES: begin
               nxt_st.en = ((nxt_st.en & ~lane) | (wbits & lane)) & PMF_EN_MASK;
            end
            PMF_ADDR_LOCK: begin
               if (ws[0]) begin
                  nxt_st.lock = wbits[0];
               end
            end
            PMF_ADDR_CTRL: begin
               if (ws[0]) begin
                  nxt_st.evmask = wbits[1:0];
                  nxt_st.por    = wbits[PMF_C_SOFT_POR];
                  nxt_st.swp    = wbits[PMF_C_SOFT_POR];
                  nxt_st.bor    = wbits[PMF_C_SOFT_BOR];
               end
            end
            PMF_ADDR_RSTVEC, PMF_ADDR_IRQVEC: begin
               nxt_st.bresp = PMF_RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = PMF_RESP_SLVERR;
            end
         endcase
      end

      // ------------------------------------------------------------
      // flags: set wins over write and vector clear; power fail clears wake flag
      // ------------------------------------------------------------
      nxt_st.flags = ((st_ff.flags & ~(wr_clr | vec_clr)) | set_v) & PMF_FLAGS_MASK;
      if (st_ff.seq_load) begin
         nxt_st.flags = (nxt_st.flags & ~PMF_SEQ_MASK) | (seq_flag_value & PMF_SEQ_MASK);
      end
      if (st_ff.ev_s2[1] & st_ff.ev_s3[1]) begin
         nxt_st.flags[PMF_F_WAKE] = 1'b0;
      end
      // overlevel/underlevel power-on reset requests
      if ((st_ff.en[PMF_E_MAIN_OVR] & main_ok & main_lvl_event)
          | (st_ff.en[PMF_E_MAIN_UND] & main_ok & main_sv_event)
          | (st_ff.en[PMF_E_CORE_OVR] & core_ok & core_lvl_event)
          | (st_ff.en[PMF_E_CORE_UND] & core_ok & core_sv_event)) begin
         nxt_st.por = 1'b1;
      end

      // ------------------------------------------------------------
      // read channel
      // ------------------------------------------------------------
      rd_ok  = 1'b1;
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         PMF_ADDR_FLAGS:   rd_val = {16'h0000, st_ff.flags & PMF_FLAGS_MASK};
         PMF_ADDR_ENABLES: rd_val = {16'h0000, st_ff.en & PMF_EN_MASK};
         PMF_ADDR_LOCK:    rd_val = {31'h0000_0000, st_ff.lock};
         PMF_ADDR_CTRL:    rd_val = {30'h0000_0000, st_ff.evmask};
         PMF_ADDR_RSTVEC:  rd_val = {16'h0000, st_ff.flags & 16'hB700};
         PMF_ADDR_IRQVEC:  rd_val = {16'h0000, st_ff.flags & st_ff.en & 16'h0077};
         default:          rd_ok = 1'b0;
      endcase
      if (s_axi_rvalid & s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = rd_val;
         nxt_st.rresp  = rd_ok ? PMF_RESP_OKAY : PMF_RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_ff          <= '0;
         st_ff.en       <= PMF_EN_RESET;
         st_ff.lock     <= 1'b0;
         st_ff.seq_load <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

// >>> dv/pmf_monitor.sv
// concurrent checks on the power monitor block's ports
`timescale 1ns/1ps
module pmf_monitor (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        deep_sleep_active,
   input wire logic        bor_request,
   input wire logic        pin_hold
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bh: assert property (p_bh) else $error("write response dropped");
   property p_bref; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_bref: assert property (p_bref) else $error("address taken during response");
   property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rref: assert property (p_rref) else $error("read taken during answer");
   property p_ra; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_ra: assert property (p_ra) else $error("read answer late");
   property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rh: assert property (p_rh) else $error("read data not held");
   property p_rz; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_rz: assert property (p_rz) else $error("upper read half not zero");
   property p_pin; pin_hold |-> deep_sleep_active; endproperty
   a_pin: assert property (p_pin) else $error("pins held outside deep sleep");
   property p_bor; bor_request |=> !bor_request; endproperty
   a_bor: assert property (p_bor) else $error("brownout trigger not self clearing");
endmodule
bind pmf_top pmf_monitor i_mon (.clk_sys, .sys_rst, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .deep_sleep_active, .bor_request, .pin_hold);

// >>> dv/pmf_supply_model.sv
// behavioural supply comparators: one-cycle events and held supply levels
`timescale 1ns/1ps
module pmf_supply_model (
   input wire logic       clk_sys,
   input wire logic [7:0] trip,
   input wire logic [2:0] lvl_req,
   output logic     [7:0] cmp_event,
   output logic     [2:0] lvl_out
);
   logic [3:0] hold_ff = 4'h0;
   logic [2:0] sel_ff = 3'b000;
   initial cmp_event = 8'h00;
   always @(posedge clk_sys) begin
      cmp_event <= trip;
      if (lvl_req != 3'b000) begin
         sel_ff <= lvl_req;
         hold_ff <= 4'h6;
      end else if (hold_ff != 4'h0) begin
         hold_ff <= hold_ff - 4'h1;
      end
   end
   // levels last long enough for the three-stage synchroniser
   assign lvl_out = (hold_ff != 4'h0) ? sel_ff : 3'b000;
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the power monitor flag and enable block
`timescale 1ns/1ps
module tb_top import pmf_pkg::*; ;
   logic clk_sys = 1'b0, sys_rst = 1'b1, dsa = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, trip = 8'h00, cmp;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [15:0] seq = 16'h0000;
   logic [2:0] lvl_req = 3'b000, lvl;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, por, bor, pin_hold, pm_irq;
   int mismatches = 0, n_compared = 0, seed = 76, n_por = 0, n_bor = 0, flg, en, lck, ctl, r;
   int fb[8] = '{0, 1, 2, 13, 4, 5, 6, 12};
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (por) n_por++;
   always @(posedge clk_sys) if (bor) n_bor++;
   pmf_top i_dut (.clk_sys, .sys_rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .seq_flag_value(seq), .wake_from_deep_sleep(lvl[0]), .main_power_fail(lvl[1]),
      .reset_pin_source(lvl[2]), .core_dly_event(cmp[0]), .core_mon_event(cmp[1]),
      .core_lvl_event(cmp[2]), .core_sv_event(cmp[3]), .main_dly_event(cmp[4]),
      .main_mon_event(cmp[5]), .main_lvl_event(cmp[6]), .main_sv_event(cmp[7]),
      .deep_sleep_active(dsa), .por_request(por), .bor_request(bor), .pin_hold, .pm_irq);
   pmf_supply_model i_sup (.clk_sys, .trip, .lvl_req, .cmp_event(cmp), .lvl_out(lvl));
   task final_report;
      if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(inout int n);
      @(posedge clk_sys);
      n++;
      if (n > 64) begin
         mismatches++;
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      int n = 0;
      bit ad = 0, wd = 0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         step(n);
         ad |= awready;
         wd |= wready;
         awvalid <= !ad;
         wvalid <= !wd;
      end while (!(ad && wd));
      bready <= 1'b1; // raised in the cycle bvalid rises, so the response is taken at once
      do step(n); while (!bvalid);
      bready <= 1'b0;
      chk(bresp, PMF_RESP_OKAY);
      case (a)
         PMF_ADDR_FLAGS: flg &= d;
         PMF_ADDR_ENABLES: en = d & 16'h3377;
         PMF_ADDR_LOCK: lck = d[0];
         PMF_ADDR_CTRL: begin
            ctl = d & 3;
            flg |= {d[3], 1'b0, d[2], 8'h00};
         end
         default: ;
      endcase
   endtask
   task automatic rd(input logic [7:0] a);
      int n = 0;
      int e = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do step(n); while (!arready);
      arvalid <= 1'b0;
      step(n);
      rready <= 1'b1;
      do step(n); while (!rvalid);
      rready <= 1'b0;
      case (a)
         PMF_ADDR_FLAGS: e = flg;
         PMF_ADDR_ENABLES: e = en;
         PMF_ADDR_LOCK: e = lck;
         PMF_ADDR_CTRL: e = ctl;
         PMF_ADDR_RSTVEC: begin
            e = flg & 16'hB700;
            flg &= ~(16'hB700 | (en[12] ? 16'h0040 : 16'h0000) | (en[8] ? 16'h0004 : 16'h0000));
         end
         PMF_ADDR_IRQVEC: begin
            e = flg & en & 16'h0077;
            flg &= ~(16'h0011 | (en[12] ? 16'h0000 : 16'h0040) | (en[8] ? 16'h0000 : 16'h0004));
            en &= ~16'h0022;
         end
         default: e = 0;
      endcase
      chk(rdata, e);
      chk(rresp, a > 8'h14 ? PMF_RESP_SLVERR : PMF_RESP_OKAY);
   endtask
   task automatic ev(input int i);
      trip <= 8'(1 << i);
      @(posedge clk_sys);
      trip <= 8'h00;
      repeat (3) @(posedge clk_sys);
      if (!ctl[i / 4]) flg |= 1 << fb[i];
   endtask
   task automatic lv(input logic [2:0] m);
      lvl_req <= m;
      @(posedge clk_sys);
      lvl_req <= 3'b000;
      repeat (12) @(posedge clk_sys);
      if (m[0]) flg |= 16'h8000;
      if (m[2]) flg |= 16'h0200;
      if (m[1]) flg &= ~16'h8000;
   endtask
   initial begin
      seq = 16'($random(seed));
      flg = seq & 16'h3044;
      en = 16'h1100;
      lck = 0;
      ctl = 0;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rd(PMF_ADDR_FLAGS);
      rd(PMF_ADDR_ENABLES);
      wr(PMF_ADDR_ENABLES, 16'hFFFF);
      rd(PMF_ADDR_ENABLES);
      wr(PMF_ADDR_FLAGS, 16'h0000);
      rd(PMF_ADDR_FLAGS);
      wr(PMF_ADDR_ENABLES, 16'h0077);
      for (int i = 0; i < 8; i++) ev(i);
      chk(pm_irq, (flg & en & 16'h0077) != 0);
      rd(PMF_ADDR_IRQVEC);
      rd(PMF_ADDR_ENABLES);
      rd(PMF_ADDR_FLAGS);
      lv(3'b101);
      rd(PMF_ADDR_FLAGS);
      lv(3'b011);
      rd(PMF_ADDR_FLAGS);
      wr(PMF_ADDR_CTRL, 16'h0008);
      wr(PMF_ADDR_CTRL, 16'h0004);
      rd(PMF_ADDR_CTRL);
      rd(PMF_ADDR_FLAGS);
      chk(n_por, 1);
      chk(n_bor, 1);
      wr(PMF_ADDR_ENABLES, 16'h1177);
      repeat (6) begin
         r = $random(seed);
         ev((r & 1) * 4 + ((r >> 1) & 3) % 3);
         chk(pm_irq, (flg & en & 16'h0077) != 0);
      end
      rd(PMF_ADDR_RSTVEC);
      rd(PMF_ADDR_FLAGS);
      wr(PMF_ADDR_CTRL, 16'h0003);
      for (int i = 0; i < 8; i++) ev(i);
      rd(PMF_ADDR_FLAGS);
      wr(PMF_ADDR_CTRL, 16'h0000);
      chk(n_por, 1);
      for (int k = 0; k < 4; k++) begin
         wr(PMF_ADDR_ENABLES, 16'(1 << (13 - k % 2 - k / 2 * 4)));
         ev(6 + k % 2 - k / 2 * 4);
         repeat (2) @(posedge clk_sys);
         chk(n_por, k + 2);
      end
      rd(PMF_ADDR_FLAGS);
      wr(PMF_ADDR_LOCK, 16'h0001);
      dsa <= 1'b1;
      rd(PMF_ADDR_LOCK);
      chk(pin_hold, 1'b1);
      wr(PMF_ADDR_LOCK, 16'h0000);
      chk(pin_hold, 1'b0);
      rd(8'h20);
      final_report();
   end
endmodule
